// ### hw/dsi_defs.svh
// Purpose: constants of the scan-port instruction decode block
// Assumes: included by its bare name from the block's files
// Notes: instruction codes are the low nibble; 8-bit standard forms carry 1111 above them, extension forms 0000
`ifndef DSI_DEFS_SVH
`define DSI_DEFS_SVH

// low three bits of the standard (upper half) instruction codes
`define DSI_CODE_ABORT 3'h0
`define DSI_CODE_PORT_REG 3'h2
`define DSI_CODE_ACC_PORT 3'h3
`define DSI_CODE_IDENT 3'h6
// top-bit markers of the 8-bit standard and extension forms, and the nibbles of the ident code
`define DSI_STD_HI8 5'h1F
`define DSI_EXT_HI8 5'h00
`define DSI_IDENT_NIB 4'hE
`define DSI_IDENT_HI8 4'hF
// value captured into the instruction shift section
`define DSI_IR_CAPTURE 8'h01
// boundary codes that must exist when any is built, and those allowed at all
`define DSI_BS_MANDATORY 8'h06
`define DSI_BS_ALLOWED 8'h77
// chain lengths
`define DSI_ACC_LEN 35
`define DSI_ID_LEN 32
`define DSI_ACC_MSB 34
`define DSI_ID_MSB 31

`endif

// ### hw/dsi_pkg.sv
// Purpose: types of the scan-port instruction decode block
// Assumes: nothing beyond the defs header
// Notes: the state struct is sized for the wider instruction register
package dsi_pkg;

    // scan port controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EX1_DR,
        TAP_PAUSE_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR,
        TAP_EX1_IR, TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
    } dsi_tap_type;

    // data chains that the current instruction can select
    typedef enum logic [2:0] {
        CH_BYPASS, CH_ABORT, CH_PORT_REG, CH_ACC_PORT, CH_IDENT, CH_BSCAN
    } dsi_chain_type;

    typedef struct packed {
        logic tck_s1;
        logic tck_s2;
        logic tck_d;
        logic tms_s1;
        logic tms_s2;
        logic tdi_s1;
        logic tdi_s2;
        logic trst_s1;
        logic trst_s2;
        dsi_tap_type state;
        logic [7:0] ir;
        logic [7:0] ir_sh;
        dsi_chain_type chain;
        logic byp;
        logic [34:0] dr_sh;
        logic tdo;
        logic tdo_oe_n;
        logic [34:0] abort_data;
        logic abort_pulse;
        logic [34:0] acc_data;
        logic acc_capture;
        logic acc_update;
        logic bs_capture;
        logic bs_shift;
        logic bs_update;
        logic bs_tdi;
    } dsi_state_type;

endpackage

// ### hw/dsi_scan_decode.sv
// Purpose: instruction register, chain decode, passthrough and cancel chains of a scan debug port
// Assumes: probe test clock far slower than ref_clk (at least 4 ref_clk per half period)
// Notes: scan pins pass two flip-flops; all scan actions except test reset happen on detected test clock edges
//
// Summary of operation
// - instruction register four or eight bits, fully decoded
// - reserved or unbuilt codes select the passthrough bit
// - cancel code selects 35-bit transaction-cancel chain
// - code 1010 selects port register access chain
// - code 1011 selects access-port chain, 35 bits
// - test-logic-reset makes identification instruction current
// - all-ones code selects the passthrough bit
// - low half codes are extensions, else passthrough
// - built boundary codes select the boundary chain
// - boundary scan needs sample and boundary_value_load codes
// - optional boundary codes fixed; unbuilt ones pass through
// - boundary scan preferably left out of this port
// - instruction shift section sole path while shifting
// - instruction capture loads binary one pattern
// - instruction bits shift least significant first
// - instruction update copies shift section to register
// - current instruction alone picks the data chain
// - passthrough delays serial data one test clock
// - passthrough capture loads a zero
// - passthrough update does nothing, bit discarded
// - test reset forces reset state and instruction only
// - chains shift one bit per rising edge, lsb out
`include "dsi_defs.svh"

module dsi_scan_decode import dsi_pkg::*; #(
    parameter int IR_W = 4,
    parameter logic [7:0] BS_IMPL = 8'h00,
    parameter logic [31:0] ID_VALUE = 32'h1234_5671
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // scan pins from the probe
    input wire logic debug_test_clock,
    input wire logic debug_mode_select,
    input wire logic debug_serial_in,
    input wire logic debug_test_reset_n,
    output logic debug_serial_out,
    output logic debug_serial_out_oe_n,
    // current selection
    output dsi_tap_type tap_state,
    output logic [7:0] instruction_register,
    output dsi_chain_type chain_select,
    // transaction-cancel chain
    output logic [34:0] cancel_data,
    output logic cancel_write,
    // register access chains
    input wire logic [34:0] access_capture_data,
    output logic access_capture,
    output logic [34:0] access_update_data,
    output logic access_update,
    // boundary chain, held outside
    input wire logic boundary_serial_in,
    output logic [2:0] boundary_instruction,
    output logic boundary_capture,
    output logic boundary_shift,
    output logic boundary_update,
    output logic boundary_data_in
);

    // ID_VALUE is arbitrary; its lsb is one as a scan identity needs
    localparam logic [7:0] BS_SET = (BS_IMPL != 8'h00) ? ((BS_IMPL | `DSI_BS_MANDATORY) & `DSI_BS_ALLOWED)
                                                        : 8'h00;
    localparam logic [7:0] IR_IDENT = (IR_W == 4) ? {4'h0, `DSI_IDENT_NIB} : {`DSI_IDENT_HI8, `DSI_IDENT_NIB};

    logic [1:0] rst_q;
    logic rst_i_n;
    dsi_state_type r, r_nxt;
    logic rise, fall;

    // instruction to chain; codes 1001, 110x, all ones and the reserved span fall to bypass
    function automatic dsi_chain_type decode_ir(input logic [7:0] v);
        logic std;
        logic ext;
        std = (IR_W == 4) ? v[3] : (v[7:3] == `DSI_STD_HI8);
        ext = (IR_W == 4) ? ~v[3] : (v[7:3] == `DSI_EXT_HI8);
        decode_ir = CH_BYPASS;
        if (std) begin
            case (v[2:0])
                `DSI_CODE_ABORT: decode_ir = CH_ABORT;
                `DSI_CODE_PORT_REG: decode_ir = CH_PORT_REG;
                `DSI_CODE_ACC_PORT: decode_ir = CH_ACC_PORT;
                `DSI_CODE_IDENT: decode_ir = CH_IDENT;
                default: decode_ir = CH_BYPASS;
            endcase
        end else if (ext && BS_SET[v[2:0]]) begin
            decode_ir = CH_BSCAN;
        end
    endfunction

    // controller step on a rising test clock edge
    function automatic dsi_tap_type tap_next(input dsi_tap_type s, input logic m);
        case (s)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EX1_DR : TAP_SHIFT_DR;
            TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EX2_DR : TAP_PAUSE_DR;
            TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EX1_IR : TAP_SHIFT_IR;
            TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EX2_IR : TAP_PAUSE_IR;
            TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction

    // reset release through two flip-flops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_q <= 2'b00;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_i_n = rst_q[1];

    // edges seen on the synchronised test clock
    assign rise = r.tck_s2 & ~r.tck_d;
    assign fall = ~r.tck_s2 & r.tck_d;

    // next state of the whole block
    always_comb begin
        r_nxt = r;
        r_nxt.tck_s1 = debug_test_clock;
        r_nxt.tck_s2 = r.tck_s1;
        r_nxt.tck_d = r.tck_s2;
        r_nxt.tms_s1 = debug_mode_select;
        r_nxt.tms_s2 = r.tms_s1;
        r_nxt.tdi_s1 = debug_serial_in;
        r_nxt.tdi_s2 = r.tdi_s1;
        r_nxt.trst_s1 = debug_test_reset_n;
        r_nxt.trst_s2 = r.trst_s1;
        r_nxt.abort_pulse = 1'b0;
        r_nxt.acc_capture = 1'b0;
        r_nxt.acc_update = 1'b0;
        r_nxt.bs_capture = 1'b0;
        r_nxt.bs_shift = 1'b0;
        r_nxt.bs_update = 1'b0;
        if (rise) begin
            r_nxt.state = tap_next(r.state, r.tms_s2);
            case (r.state)
                TAP_CAP_IR: r_nxt.ir_sh = `DSI_IR_CAPTURE;
                TAP_SHIFT_IR: begin
                    // lsb leaves first, new bit enters at the top of the chosen width
                    r_nxt.ir_sh = {1'b0, r.ir_sh[7:1]};
                    r_nxt.ir_sh[IR_W - 1] = r.tdi_s2;
                end
                TAP_UPD_IR: begin
                    r_nxt.ir = r.ir_sh;
                    r_nxt.chain = decode_ir(r.ir_sh);
                end
                TAP_CAP_DR: begin
                    case (r.chain)
                        CH_ABORT: r_nxt.dr_sh = '0;
                        CH_PORT_REG, CH_ACC_PORT: begin
                            r_nxt.dr_sh = access_capture_data;
                            r_nxt.acc_capture = 1'b1;
                        end
                        CH_IDENT: r_nxt.dr_sh = {3'h0, ID_VALUE};
                        CH_BSCAN: r_nxt.bs_capture = 1'b1;
                        default: r_nxt.byp = 1'b0;
                    endcase
                end
                TAP_SHIFT_DR: begin
                    r_nxt.dr_sh = {1'b0, r.dr_sh[34:1]};
                    if (r.chain == CH_IDENT) begin
                        r_nxt.dr_sh[`DSI_ID_MSB] = r.tdi_s2;
                    end else begin
                        r_nxt.dr_sh[`DSI_ACC_MSB] = r.tdi_s2;
                    end
                    r_nxt.byp = r.tdi_s2;
                    r_nxt.bs_shift = (r.chain == CH_BSCAN);
                    r_nxt.bs_tdi = r.tdi_s2;
                end
                TAP_UPD_DR: begin
                    case (r.chain)
                        CH_ABORT: begin
                            r_nxt.abort_data = r.dr_sh;
                            r_nxt.abort_pulse = 1'b1;
                        end
                        CH_PORT_REG, CH_ACC_PORT: begin
                            r_nxt.acc_data = r.dr_sh;
                            r_nxt.acc_update = 1'b1;
                        end
                        CH_BSCAN: r_nxt.bs_update = 1'b1;
                        default: r_nxt.acc_update = 1'b0;
                    endcase
                end
                default: r_nxt.byp = r.byp;
            endcase
        end
        // output moves only on the falling edge so the probe samples a settled bit
        if (fall) begin
            r_nxt.tdo_oe_n = ~(r.state == TAP_SHIFT_IR || r.state == TAP_SHIFT_DR);
            if (r.state == TAP_SHIFT_IR) begin
                r_nxt.tdo = r.ir_sh[0];
            end else if (r.state == TAP_SHIFT_DR) begin
                case (r.chain)
                    CH_BYPASS: r_nxt.tdo = r.byp;
                    CH_BSCAN: r_nxt.tdo = boundary_serial_in;
                    default: r_nxt.tdo = r.dr_sh[0];
                endcase
            end
        end
        // reset state, whether reached by mode select or by the test reset pin
        if (r.state == TAP_RESET) begin
            r_nxt.ir = IR_IDENT;
            r_nxt.chain = CH_IDENT;
        end
        // test reset touches only the controller and the instruction
        if (!r.trst_s2) begin
            r_nxt.state = TAP_RESET;
            r_nxt.ir = IR_IDENT;
            r_nxt.chain = CH_IDENT;
        end
    end

    // single register for all state except the reset synchroniser
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            r <= '{state: TAP_RESET, ir: IR_IDENT, chain: CH_IDENT, tdo_oe_n: 1'b1, trst_s1: 1'b1,
                   trst_s2: 1'b1, default: '0};
        end else begin
            r <= r_nxt;
        end
    end

    assign debug_serial_out = r.tdo;
    assign debug_serial_out_oe_n = r.tdo_oe_n;
    assign tap_state = r.state;
    assign instruction_register = r.ir;
    assign chain_select = r.chain;
    assign cancel_data = r.abort_data;
    assign cancel_write = r.abort_pulse;
    assign access_capture = r.acc_capture;
    assign access_update_data = r.acc_data;
    assign access_update = r.acc_update;
    assign boundary_instruction = r.ir[2:0];
    assign boundary_capture = r.bs_capture;
    assign boundary_shift = r.bs_shift;
    assign boundary_update = r.bs_update;
    assign boundary_data_in = r.bs_tdi;

    // checks on the scan behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_i_n);

    // a detected rise in a given state, qualified by a condition
    sequence s_rise_in(dsi_tap_type st, logic cond);
        rise && r.state == st && cond;
    endsequence

    // output side of a step, seen at the falling edge inside a given state
    sequence s_fall_in(dsi_tap_type st, logic cond);
        fall && r.state == st && cond;
    endsequence

    property p_ir_capture;
        s_rise_in(TAP_CAP_IR, r.trst_s2) |=> r.ir_sh == `DSI_IR_CAPTURE;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("capture pattern wrong");

    property p_ir_update;
        s_rise_in(TAP_UPD_IR, r.trst_s2) |=> r.ir == $past(r.ir_sh) && r.chain == decode_ir($past(r.ir_sh));
    endproperty
    a_ir_update: assert property (p_ir_update) else $error("instruction not updated");

    property p_reset_ident;
        r.state == TAP_RESET |=> r.ir == IR_IDENT && r.chain == CH_IDENT;
    endproperty
    a_reset_ident: assert property (p_reset_ident) else $error("reset did not select ident");

    property p_trst;
        !r.trst_s2 |=> r.state == TAP_RESET ##1 r.ir == IR_IDENT;
    endproperty
    a_trst: assert property (p_trst) else $error("test reset ignored");

    property p_tdo_on_fall;
        $changed(r.tdo) |-> $past(fall);
    endproperty
    a_tdo_on_fall: assert property (p_tdo_on_fall) else $error("output moved off falling edge");

    property p_byp_capture;
        s_rise_in(TAP_CAP_DR, r.chain == CH_BYPASS) |=> !r.byp;
    endproperty
    a_byp_capture: assert property (p_byp_capture) else $error("bypass capture not zero");

    property p_byp_update;
        s_rise_in(TAP_UPD_DR, r.chain == CH_BYPASS) |=> !r.acc_update && !r.abort_pulse && !r.bs_update;
    endproperty
    a_byp_update: assert property (p_byp_update) else $error("bypass update had an effect");

    // first half of the one-clock delay: the bit is taken at the rise
    property p_byp_shift;
        s_rise_in(TAP_SHIFT_DR, r.chain == CH_BYPASS) |=> r.byp == $past(r.tdi_s2);
    endproperty
    a_byp_shift: assert property (p_byp_shift) else $error("bypass bit not taken");

    // second half: the held bit is shown at the following fall
    property p_byp_delay;
        s_fall_in(TAP_SHIFT_DR, r.chain == CH_BYPASS) |=> r.tdo == $past(r.byp);
    endproperty
    a_byp_delay: assert property (p_byp_delay) else $error("bypass delay wrong");

    property p_cancel_shift;
        s_rise_in(TAP_SHIFT_DR, r.chain == CH_ABORT) |=> r.dr_sh[34] == $past(r.tdi_s2)
            && r.dr_sh[33:0] == $past(r.dr_sh[34:1]);
    endproperty
    a_cancel_shift: assert property (p_cancel_shift) else $error("cancel chain shift wrong");

    property p_ir_out;
        s_fall_in(TAP_SHIFT_IR, 1'b1) |=> r.tdo == $past(r.ir_sh[0]) && !r.tdo_oe_n;
    endproperty
    a_ir_out: assert property (p_ir_out) else $error("instruction shift not on output");

    property p_cancel_write;
        s_rise_in(TAP_UPD_DR, r.chain == CH_ABORT) |=> r.abort_pulse ##1 !r.abort_pulse;
    endproperty
    a_cancel_write: assert property (p_cancel_write) else $error("cancel write pulse wrong");

endmodule

// ### sim/dsi_probe.sv
// Purpose: behavioural debug probe that drives the scan pins of the decode block
// Assumes: test clock period of 8 ref_clk cycles (320 ns), held low between frames
// Notes: pins change just after a ref_clk edge; serial out is sampled just before each test clock rise
module dsi_probe (
    // reference clock
    input wire logic ref_clk,
    // scan pins towards the device
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    // serial data from the device
    input wire logic tdo
);
    timeunit 1ns;
    timeprecision 1ns;

    // idle pin levels, test clock stands still low
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // one test clock: low half with new pins, sample serial out, high half
    task automatic pulse(input logic m, input logic d, output logic q);
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge ref_clk);
        q = tdo;
        tck <= 1'b1;
        repeat (4) @(posedge ref_clk);
        tck <= 1'b0;
    endtask

    // five clocks with mode select high, then settle in idle; tdi toggles so it is never trusted
    task automatic go_reset();
        logic q;
        repeat (5) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
    endtask

    // from idle: one instruction or data scan, lsb first, back to idle with one spare clock
    task automatic scan(input logic ir, input logic [34:0] din, input int len, output logic [34:0] dout);
        logic q;
        dout = '0;
        pulse(1'b1, ~tdi, q);
        if (ir) pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        for (int i = 0; i < len; i++) begin
            pulse(i == len - 1, din[i], q);
            dout[i] = q;
        end
        pulse(1'b1, ~tdi, q);
        pulse(1'b0, ~tdi, q);
        pulse(1'b0, ~tdi, q);
    endtask

    // test reset held longer than the device's synchroniser needs
    task automatic test_reset();
        trst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        trst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
    endtask
endmodule

// ### sim/tb.sv
// Purpose: self-checking bench of the scan-port instruction decode block
// Assumes: main instance 4-bit with no boundary codes; second instance 8-bit with some
// Notes: all scan traffic goes through the probe model's tasks
module tb import dsi_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;

    // identification value is arbitrary
    localparam logic [31:0] ID_V = 32'h1234_5671;
    localparam int LIMIT = 40000;

    logic ref_clk, rst_n, tck, tms, tdi, trst_n, tdo, tdo_oe_n, cancel_write, acc_capture, acc_update, bs_in;
    dsi_tap_type tap_state;
    dsi_chain_type chain;
    logic [7:0] ir;
    logic [34:0] cancel_data, acc_cap_data, acc_upd_data;
    logic tdo_q;
    logic tck8, tms8, tdi8, trst8_n, tdo8, bs_cap, bs_shift, bs_upd;
    logic [7:0] ir8;
    logic [2:0] bs_ins;
    dsi_chain_type chain8;
    int n_errors, n_checks, n_cancel, n_upd, cycles;
    int n_cap, n_bs_cap, n_bs_shift, n_bs_upd;

    dsi_scan_decode #(.IR_W(4), .BS_IMPL(8'h00), .ID_VALUE(ID_V)) u_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .debug_test_clock(tck), .debug_mode_select(tms),
        .debug_serial_in(tdi), .debug_test_reset_n(trst_n), .debug_serial_out(tdo),
        .debug_serial_out_oe_n(tdo_oe_n), .tap_state(tap_state), .instruction_register(ir),
        .chain_select(chain), .cancel_data(cancel_data), .cancel_write(cancel_write),
        .access_capture_data(acc_cap_data), .access_capture(acc_capture),
        .access_update_data(acc_upd_data), .access_update(acc_update), .boundary_serial_in(bs_in),
        .boundary_instruction(), .boundary_capture(), .boundary_shift(), .boundary_update(),
        .boundary_data_in()
    );

    dsi_probe u_probe (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

    // wide build asking for boundary codes 4 and 5; sample and boundary_value_load must come with them
    dsi_scan_decode #(.IR_W(8), .BS_IMPL(8'h30), .ID_VALUE(ID_V)) u_dut8 (
        .ref_clk(ref_clk), .rst_n(rst_n), .debug_test_clock(tck8), .debug_mode_select(tms8),
        .debug_serial_in(tdi8), .debug_test_reset_n(trst8_n), .debug_serial_out(tdo8),
        .debug_serial_out_oe_n(), .tap_state(), .instruction_register(ir8),
        .chain_select(chain8), .cancel_data(), .cancel_write(),
        .access_capture_data(acc_cap_data), .access_capture(),
        .access_update_data(), .access_update(), .boundary_serial_in(bs_in),
        .boundary_instruction(bs_ins), .boundary_capture(bs_cap), .boundary_shift(bs_shift),
        .boundary_update(bs_upd), .boundary_data_in()
    );

    dsi_probe u_probe8 (.ref_clk(ref_clk), .tck(tck8), .tms(tms8), .tdi(tdi8), .trst_n(trst8_n), .tdo(tdo8));

    // reference clock, 40 ns
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [34:0] got, input logic [34:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // chain each 4-bit code must pick when no boundary code is built
    function automatic dsi_chain_type exp_chain(input logic [3:0] c);
        case (c)
            4'h8: return CH_ABORT;
            4'hA: return CH_PORT_REG;
            4'hB: return CH_ACC_PORT;
            4'hE: return CH_IDENT;
            default: return CH_BYPASS;
        endcase
    endfunction

    // 8-bit codes: standard ones carry 1111 above the 4-bit low bits; boundary set is 1, 2, 4, 5
    function automatic dsi_chain_type exp_chain8(input logic [7:0] c);
        if (c[7:3] == 5'h1F) return exp_chain(c[3:0]);
        if (c == 8'h01 || c == 8'h02 || c == 8'h04 || c == 8'h05) return CH_BSCAN;
        return CH_BYPASS;
    endfunction

    // pulse counters, timeout, and serial out frozen while the test clock pin is high
    always @(posedge ref_clk) begin
        cycles++;
        tdo_q <= tdo;
        if (cancel_write === 1'b1) n_cancel++;
        if (acc_update === 1'b1) n_upd++;
        if (acc_capture === 1'b1) n_cap++;
        if (bs_cap === 1'b1) n_bs_cap++;
        if (bs_shift === 1'b1) n_bs_shift++;
        if (bs_upd === 1'b1) n_bs_upd++;
        if (rst_n && tck && tdo !== tdo_q) begin
            n_errors++;
            $display("Error at %0t: serial out moved with test clock high", $time);
        end
        if (cycles == LIMIT) begin
            n_errors++;
            $display("Error at %0t: run did not finish in time", $time);
            final_report();
        end
    end

    initial begin
        logic [34:0] d;
        int c0;
        int c1;
        rst_n = 1'b0;
        acc_cap_data = 35'h0;
        bs_in = 1'b0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check(35'(tap_state), 35'(TAP_RESET), "reset state");
        check(35'(ir), 35'h0E, "reset instruction");
        // ident chain: 33 clocks show 32 bits of value, then the first bit sent
        u_probe.go_reset();
        u_probe.scan(1'b0, 35'h1, 33, d);
        check(d, {2'h0, 1'b1, ID_V}, "ident chain");
        // every 4-bit code: capture pattern, update, decode
        for (int c = 0; c < 16; c++) begin
            u_probe.scan(1'b1, 35'(c), 4, d);
            check(d, 35'h1, "instruction capture");
            check(35'(ir), 35'(c), "current instruction");
            check(35'(chain), 35'(exp_chain(4'(c))), "chain decode");
        end
        // passthrough: zero captured, one clock delay, update has no effect
        c0 = n_cancel + n_upd;
        u_probe.scan(1'b0, 35'hA5, 8, d);
        check(d, 35'h4A, "passthrough delay");
        check(35'(n_cancel + n_upd - c0), 35'h0, "passthrough update");
        check(35'(tdo_oe_n), 35'h1, "output enable off outside shift");
        // transaction cancel with the only value an early port accepts
        u_probe.scan(1'b1, 35'h8, 4, d);
        c0 = n_cancel;
        u_probe.scan(1'b0, 35'h8, 35, d);
        check(d, 35'h0, "cancel capture");
        check(cancel_data, 35'h8, "cancel data");
        check(35'(n_cancel - c0), 35'h1, "cancel write count");
        // both register access chains: captured word out, scanned word handed over once
        for (int c = 10; c < 12; c++) begin
            u_probe.scan(1'b1, 35'(c), 4, d);
            acc_cap_data <= 35'h2_1234_567A + 35'(c);
            c0 = n_upd;
            c1 = n_cap;
            u_probe.scan(1'b0, 35'h5_0F0F_0F0F ^ 35'(c), 35, d);
            check(d, acc_cap_data, "access capture");
            check(acc_upd_data, 35'h5_0F0F_0F0F ^ 35'(c), "access update");
            check(35'(n_upd - c0), 35'h1, "access update count");
            check(35'(n_cap - c1), 35'h1, "access capture count");
        end
        // test reset restores the reset state and the instruction only
        u_probe.test_reset();
        check(35'(ir), 35'h0E, "test reset instruction");
        check(35'(tap_state), 35'(TAP_RESET), "test reset state");
        check(cancel_data, 35'h8, "test reset leaves cancel data");
        // five clocks with mode select high also restore the ident instruction
        u_probe.go_reset();
        u_probe.scan(1'b1, 35'hF, 4, d);
        check(35'(chain), 35'(CH_BYPASS), "all-ones code");
        u_probe.go_reset();
        check(35'(ir), 35'h0E, "synchronous reset instruction");
        // wide build: reset ident, then every 8-bit code captured, loaded and decoded
        check(35'(ir8), 35'hFE, "wide reset instruction");
        u_probe8.go_reset();
        for (int c = 0; c < 256; c++) begin
            u_probe8.scan(1'b1, 35'(c), 8, d);
            check(d, 35'h01, "wide instruction capture");
            check(35'(ir8), 35'(c), "wide current instruction");
            check(35'(chain8), 35'(exp_chain8(8'(c))), "wide chain decode");
        end
        // boundary chain: one capture, one strobe per shifted bit, one update, outside bit on serial out
        u_probe8.scan(1'b1, 35'h01, 8, d);
        bs_in <= 1'b1;
        u_probe8.scan(1'b0, 35'h0, 6, d);
        check(d, 35'h3F, "boundary serial out");
        check(35'(bs_ins), 35'h1, "boundary instruction");
        check(35'(n_bs_shift), 35'h6, "boundary shift count");
        check(35'(n_bs_cap + n_bs_upd), 35'h2, "boundary capture and update");
        final_report();
    end
endmodule
